// ### design/trig_qual_pkg.sv
package trig_qual_pkg;

    // sample and setting widths
    localparam int SAMPLE_W    = 16;
    localparam int PCT_W       = 11;   // tenths of a percent, signed
    localparam int POS_W       = 7;    // whole percent 0..100
    localparam int ADDR_W      = 12;
    localparam int DELAY_W     = 21;   // half-microsecond steps

    // percentage scale in tenths, position scale in whole percent
    localparam logic signed [PCT_W-1:0] PCT_FULL   = 11'sd1000;
    localparam logic        [PCT_W-1:0] WIDTH_FULL = 11'd2000;
    localparam logic        [POS_W-1:0] POS_FULL   = 7'd100;

    // delay limits
    localparam real DELAY_MAX_US   = 1000000.0;
    localparam real DELAY_STEP_US  = 0.5;
    localparam real CLK_PERIOD_NS  = 10.0;
    localparam int  DELAY_STEP_CYC = int'(DELAY_STEP_US * 1000.0
                                          / CLK_PERIOD_NS);
    localparam logic [DELAY_W-1:0] DELAY_MAX_STEPS = 21'd2000000;

    // reset values of settings
    localparam logic signed [PCT_W-1:0] LEVEL_RST  = 11'sd0;
    localparam logic        [PCT_W-1:0] WIDTH_RST  = 11'd0;
    localparam logic        [POS_W-1:0] POS_RST    = 7'd0;

    // trigger modes
    typedef enum logic [2:0] {
        MODE_OFF       = 3'h0,
        MODE_AUTO      = 3'h1,
        MODE_AUTO_CTR  = 3'h2,
        MODE_NORMAL    = 3'h3,
        MODE_ZC_AUTO   = 3'h4,
        MODE_ZC_NORMAL = 3'h5
    } trig_mode_t;

    // slopes
    typedef enum logic [1:0] {
        SLOPE_RISE = 2'h0,
        SLOPE_FALL = 2'h1,
        SLOPE_BOTH = 2'h2
    } slope_t;

    // scale a signed tenth-percent to sample units of a channel range
    function automatic logic signed [SAMPLE_W-1:0] pct_to_sample(
        input logic signed [PCT_W:0]      pct,
        input logic        [SAMPLE_W-2:0] range
    );
        logic signed [SAMPLE_W+PCT_W+1:0] prod;
        logic signed [SAMPLE_W+PCT_W+1:0] quo;
        begin
            prod = pct * $signed({1'b0, range});
            quo  = prod / (SAMPLE_W+PCT_W+2)'(1000);
            if (quo > $signed({1'b0, range}))
                pct_to_sample = $signed({1'b0, range});
            else if (quo < -$signed({1'b0, range}))
                pct_to_sample = -$signed({1'b0, range});
            else
                pct_to_sample = quo[SAMPLE_W-1:0];
        end
    endfunction

endpackage

// ### design/crossing_if.sv
`timescale 1ns/10ps
`default_nettype none

// compare results passed from the detector to the qualifier core
interface crossing_if;
    import trig_qual_pkg::*;
    logic above_q;
    logic in_band_q;
    logic valid_q;
    logic prev_above_q;
    logic prev_in_q;
    modport detector (output above_q, in_band_q, valid_q,
                      prev_above_q, prev_in_q);
    modport core     (input above_q, in_band_q, valid_q,
                      prev_above_q, prev_in_q);
endinterface

`default_nettype wire

// ### design/sample_compare.sv
`timescale 1ns/10ps
`default_nettype none

module sample_compare
    import trig_qual_pkg::*;
(
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    input  wire logic                       clear,
    // sample and thresholds
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] sample,
    input  wire logic signed [SAMPLE_W-1:0] level,
    input  wire logic signed [SAMPLE_W-1:0] win_lo,
    input  wire logic signed [SAMPLE_W-1:0] win_hi,
    // results
    crossing_if.detector                    cmp
);

    logic above_d, in_d, valid_d, pa_d, pi_d;

    // current compare plus the previous one; clear forgets history
    always_comb
    begin
        above_d = cmp.above_q;
        in_d    = cmp.in_band_q;
        valid_d = cmp.valid_q;
        pa_d    = cmp.prev_above_q;
        pi_d    = cmp.prev_in_q;
        if (clear)
        begin
            valid_d = 1'b0;                       // RULE23
        end
        else if (sample_valid)
        begin
            pa_d    = cmp.above_q;
            pi_d    = cmp.in_band_q;
            above_d = sample > level;              // RULE4
            in_d    = (sample >= win_lo) && (sample <= win_hi);
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmp.above_q      <= 1'b0;
            cmp.in_band_q    <= 1'b0;
            cmp.valid_q      <= 1'b0;
            cmp.prev_above_q <= 1'b0;
            cmp.prev_in_q    <= 1'b0;
        end
        else
        begin
            cmp.above_q      <= above_d;
            cmp.in_band_q    <= in_d;
            cmp.valid_q      <= valid_d;
            cmp.prev_above_q <= pa_d;
            cmp.prev_in_q    <= pi_d;
        end
    end

endmodule

`default_nettype wire

// ### design/trigger_qualifier.sv
// Summary of operation
// (RULE1) rising slope fires when sample goes from below level to above
// (RULE2) falling slope fires when sample goes from above level to below
// (RULE3) both slopes fire on either crossing direction
// (RULE4) edge type uses trigger level, 0 to +-100 percent, as threshold
// (RULE5) 0 percent is zero, +-100 percent is channel full range
// (RULE6) level ignored in off, zero-cross, and timed-out auto-centre
// (RULE7) outside trigger connector source ignores programmed level
// (RULE8) level writes refused while a zero-cross mode is active
// (RULE9) window enter fires on outside-to-inside move
// (RULE10) window leave fires on inside-to-outside move
// (RULE11) window band is centre level plus width, centre +-100 percent
// (RULE12) window width accepted from 0 to 200 percent
// (RULE13) window clamped to full-scale range
// (RULE14) window ignored in off/zero-cross; not selectable in auto-centre
// (RULE15) trigger position 0 to 100 percent of displayed record
// (RULE16) position picks the memory segment shown
// (RULE17) zero delay puts trigger sample exactly at the position
// (RULE18) position writes while stopped apply at next start
// (RULE19) observation time change recentres display on trigger position
// (RULE20) outside connector source allows only edge type
// (RULE21) delay 0 to 1000000 us in half-us steps offsets display
// (RULE22) compare current and previous sample each clock, one-cycle pulse
// (RULE23) clear forgets previous sample so no trigger on first sample
`timescale 1ns/10ps
`default_nettype none

module trigger_qualifier
    import trig_qual_pkg::*;
#(
    parameter int REC_LEN = 1000
)
(
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    input  wire logic                       sync_clear,
    // sampled source data
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] source_sample,
    input  wire logic        [SAMPLE_W-2:0] source_range,
    input  wire logic        [ADDR_W-1:0]   write_addr,
    // trigger settings
    input  wire logic        [2:0]          trig_mode,
    input  wire logic                       auto_timed_out,
    input  wire logic                       outside_trigger_connector,
    input  wire logic                       ext_trig_pulse,
    input  wire logic                       window_type,
    input  wire logic                       window_leave,
    input  wire logic        [1:0]          slope_sel,
    input  wire logic                       level_wr,
    input  wire logic signed [PCT_W-1:0]    level_pct,
    input  wire logic                       window_wr,
    input  wire logic signed [PCT_W-1:0]    center_pct,
    input  wire logic        [PCT_W-1:0]    width_pct,
    input  wire logic                       pos_wr,
    input  wire logic        [POS_W-1:0]    pos_pct,
    input  wire logic                       delay_wr,
    input  wire logic        [DELAY_W-1:0]  delay_steps,
    // acquisition control
    input  wire logic                       acq_run,
    input  wire logic                       obs_time_change,
    // results
    output var  logic                       trig_pulse,
    output var  logic                       level_refused,
    output var  logic        [ADDR_W-1:0]   display_start,
    output var  logic        [ADDR_W-1:0]   display_center,
    output var  logic        [POS_W-1:0]    pos_active,
    output var  logic        [DELAY_W-1:0]  delay_active,
    output var  logic                       window_active
);

    localparam logic [ADDR_W-1:0] REC_LEN_A = ADDR_W'(REC_LEN);

    // settings registers
    logic signed [PCT_W-1:0]   level_q, level_d;
    logic signed [PCT_W-1:0]   center_q, center_d;
    logic        [PCT_W-1:0]   width_q, width_d;
    logic        [POS_W-1:0]   pos_pend_q, pos_pend_d;
    logic        [POS_W-1:0]   pos_q, pos_d;
    logic        [DELAY_W-1:0] delay_q, delay_d;
    logic                      run_q, run_d;
    logic                      refuse_q, refuse_d;
    logic                      win_q, win_d;
    logic                      zc_mode, chg_clear;

    always_comb
    begin
        zc_mode = (trig_mode == MODE_ZC_AUTO) || (trig_mode == MODE_ZC_NORMAL);
    end

    // setting capture with range checks
    always_comb
    begin
        level_d    = level_q;
        center_d   = center_q;
        width_d    = width_q;
        pos_pend_d = pos_pend_q;
        pos_d      = pos_q;
        delay_d    = delay_q;
        run_d      = acq_run;
        refuse_d   = 1'b0;
        win_d      = window_type;
        if (level_wr)
        begin
            if (zc_mode)
                refuse_d = 1'b1;                   // RULE8
            else if (level_pct <= PCT_FULL && level_pct >= -PCT_FULL)
                level_d = level_pct;               // RULE4
        end
        if (window_wr)
        begin
            if (center_pct <= PCT_FULL && center_pct >= -PCT_FULL)
                center_d = center_pct;             // RULE11
            if (width_pct <= WIDTH_FULL)
                width_d = width_pct;               // RULE12
        end
        if (pos_wr && pos_pct <= POS_FULL)
            pos_pend_d = pos_pct;                  // RULE15
        if (acq_run && !run_q)
            pos_d = pos_pend_d;                    // RULE18
        else if (acq_run && pos_wr && pos_pct <= POS_FULL)
            pos_d = pos_pct;
        if (delay_wr && delay_steps <= DELAY_MAX_STEPS)
            delay_d = delay_steps;                 // RULE21
        // window not usable in auto-centre or with the outside connector
        if (trig_mode == MODE_AUTO_CTR || outside_trigger_connector)
            win_d = 1'b0;                          // RULE14 RULE20
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            level_q    <= LEVEL_RST;
            center_q   <= LEVEL_RST;
            width_q    <= WIDTH_RST;
            pos_pend_q <= POS_RST;
            pos_q      <= POS_RST;
            delay_q    <= '0;
            run_q      <= 1'b0;
            refuse_q   <= 1'b0;
            win_q      <= 1'b0;
        end
        else
        begin
            level_q    <= level_d;
            center_q   <= center_d;
            width_q    <= width_d;
            pos_pend_q <= pos_pend_d;
            pos_q      <= pos_d;
            delay_q    <= delay_d;
            run_q      <= run_d;
            refuse_q   <= refuse_d;
            win_q      <= win_d;
        end
    end

    // thresholds in sample units; band clamped by the scaling function
    logic signed [SAMPLE_W-1:0] level_s, lo_s, hi_s;
    always_comb
    begin
        level_s = pct_to_sample({level_q[PCT_W-1], level_q},
                                source_range);                 // RULE5
        // band edges fit the 12-bit argument: centre and half width
        // are each at most 1000 tenths, so the cut loses nothing
        lo_s    = pct_to_sample((PCT_W+1)'({center_q[PCT_W-1], center_q}
                                - $signed({1'b0, width_q}) / 2),
                                source_range);                 // RULE11 RULE13
        hi_s    = pct_to_sample((PCT_W+1)'({center_q[PCT_W-1], center_q}
                                + $signed({1'b0, width_q}) / 2),
                                source_range);                 // RULE13
    end

    // sync_clear and level, window or window-type changes forget history to avoid false crossings
    always_comb
    begin
        chg_clear = sync_clear || level_wr || window_wr
                    || (win_d != win_q);                       // RULE23
    end

    crossing_if cmp ();

    sample_compare u_cmp (
        .mclk         (mclk),
        .resetn       (resetn),
        .clear        (chg_clear),
        .sample_valid (sample_valid),
        .sample       (source_sample),
        .level        (level_s),
        .win_lo       (lo_s),
        .win_hi       (hi_s),
        .cmp          (cmp.detector)
    );

    // qualification
    logic fire, rise, fall, enter, leave, level_void, hist_ok;
    always_comb
    begin
        hist_ok = cmp.valid_q && sample_valid && !chg_clear;   // RULE22
        rise  = !cmp.above_q && (source_sample > level_s);     // RULE1
        fall  = cmp.above_q && !(source_sample > level_s);     // RULE2
        enter = !cmp.in_band_q && (source_sample >= lo_s)
                && (source_sample <= hi_s);                    // RULE9
        leave = cmp.in_band_q && !((source_sample >= lo_s)
                && (source_sample <= hi_s));                   // RULE10
        level_void = (trig_mode == MODE_OFF) || zc_mode
                     || (trig_mode == MODE_AUTO_CTR
                         && auto_timed_out);                   // RULE6
        fire = 1'b0;
        if (outside_trigger_connector)
            fire = ext_trig_pulse && trig_mode != MODE_OFF;    // RULE7
        else if (!level_void && hist_ok)
        begin
            if (win_q)
                fire = window_leave ? leave : enter;           // RULE14
            else
                case (slope_sel)
                    SLOPE_RISE: fire = rise;
                    SLOPE_FALL: fire = fall;
                    SLOPE_BOTH: fire = rise || fall;           // RULE3
                    default:    fire = 1'b0;
                endcase
        end
    end

    // display window placement
    logic [ADDR_W-1:0] pre_d, start_d, center_d2, start_q, center_q2;
    logic              pulse_q;
    logic [ADDR_W+POS_W-1:0] prod;
    always_comb
    begin
        prod      = {{POS_W{1'b0}}, REC_LEN_A} * {{ADDR_W{1'b0}}, pos_q};
        pre_d     = ADDR_W'(prod / (ADDR_W+POS_W)'(POS_FULL));   // RULE15
        start_d   = start_q;
        center_d2 = center_q2;
        if (fire && delay_q == '0)
            start_d = write_addr - pre_d;                      // RULE16 RULE17
        else if (fire)
            start_d = write_addr - pre_d
                      + ADDR_W'(delay_q * DELAY_STEP_CYC);     // RULE21
        if (obs_time_change)
            center_d2 = start_q + pre_d;                       // RULE19
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            start_q   <= '0;
            center_q2 <= '0;
            pulse_q   <= 1'b0;
        end
        else
        begin
            start_q   <= start_d;
            center_q2 <= center_d2;
            pulse_q   <= fire;                                 // RULE22
        end
    end

    // outputs straight from registers
    always_comb
    begin
        trig_pulse     = pulse_q;
        level_refused  = refuse_q;
        display_start  = start_q;
        display_center = center_q2;
        pos_active     = pos_q;
        delay_active   = delay_q;
        window_active  = win_q;
    end

endmodule

`default_nettype wire

// ### test/trig_qual_chk.sv
`timescale 1ns/10ps
`default_nettype none

module trig_qual_chk
    import trig_qual_pkg::*;
#(
    parameter int REC_LEN = 1000
)
(
    // clock and reset
    input wire logic               mclk,
    input wire logic               resetn,
    // watched inputs
    input wire logic               sample_valid,
    input wire logic [2:0]         trig_mode,
    input wire logic               outside_trigger_connector,
    input wire logic               ext_trig_pulse,
    input wire logic               level_wr,
    input wire logic               acq_run,
    // watched outputs
    input wire logic               trig_pulse,
    input wire logic               level_refused,
    input wire logic [POS_W-1:0]   pos_active,
    input wire logic [DELAY_W-1:0] delay_active,
    input wire logic               window_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // mode or source held two cycles, so registered outputs have caught up; zc_write is one cycle
    sequence auto_ctr_held;
        (trig_mode == 3'h2) [*2];
    endsequence
    sequence ext_held;
        outside_trigger_connector [*2];
    endsequence
    sequence zc_write;
        level_wr && (trig_mode == 3'h4 || trig_mode == 3'h5);
    endsequence

    AST_PULSE_CAUSE: assert property (
        trig_pulse |-> $past(sample_valid) || $past(ext_trig_pulse))
        else $error("trigger pulse without a sample");
    AST_REFUSE: assert property (zc_write |=> level_refused)
        else $error("level write not refused");
    AST_REFUSE_CAUSE: assert property (
        level_refused |-> $past(level_wr)
                          && $past(trig_mode) inside {3'h4, 3'h5})
        else $error("refusal without a zero-cross write");
    AST_OFF_QUIET: assert property (
        $past(trig_mode) == 3'h0 |-> !trig_pulse)
        else $error("trigger while off");
    AST_WIN_AUTOCTR: assert property (
        auto_ctr_held |-> !window_active)
        else $error("window type in auto-centre mode");
    AST_WIN_EXT: assert property (ext_held |-> !window_active)
        else $error("window type with outside source");
    AST_EXT_ONLY: assert property (
        ext_held ##0 trig_pulse |-> $past(ext_trig_pulse))
        else $error("sample trigger with outside source");
    AST_POS_RANGE: assert property (pos_active <= POS_FULL)
        else $error("position above full");
    AST_POS_STOPPED: assert property (
        !acq_run && $past(acq_run) == 1'b0 |-> $stable(pos_active))
        else $error("position changed while stopped");
    AST_DELAY_RANGE: assert property (
        delay_active <= DELAY_MAX_STEPS)
        else $error("delay above maximum");
endmodule

`default_nettype wire

// ### test/sample_source.sv
`timescale 1ns/10ps
`default_nettype none

// far side: channel samples with their memory write address
module sample_source
    import trig_qual_pkg::*;
(
    // clock
    input  wire logic                       mclk,
    // sample stream
    output var  logic                       sample_valid,
    output var  logic signed [SAMPLE_W-1:0] source_sample,
    output var  logic        [ADDR_W-1:0]   write_addr
);
    initial
    begin
        sample_valid  = 1'b0;
        source_sample = 16'h0000;
        write_addr    = 12'h000;
    end

    // one sample for one clock; stale data is inverted, never held
    task automatic send(input logic signed [SAMPLE_W-1:0] v,
                        input logic        [ADDR_W-1:0]   a);
        @(negedge mclk);
        sample_valid  <= 1'b1;
        source_sample <= v;
        write_addr    <= a;
        @(negedge mclk);
        sample_valid  <= 1'b0;
        source_sample <= ~v;
        write_addr    <= a + 12'h001;
    endtask
endmodule

`default_nettype wire

// ### test/waveform_trigger_qualifier_test.sv
`timescale 1ns/10ps
`default_nettype none

module waveform_trigger_qualifier_test;
    import trig_qual_pkg::*;

    localparam int REC = 100;
    localparam int LVL = 0;
    localparam int WIN = 1;
    localparam int POS = 2;
    localparam int DLY = 3;

    logic                       mclk, resetn, sync_clear, auto_timed_out;
    logic                       outside_trigger_connector, ext_trig_pulse;
    logic                       window_type, window_leave, level_wr;
    logic                       window_wr, pos_wr, delay_wr, acq_run;
    logic                       obs_time_change, sample_valid;
    logic                       trig_pulse, level_refused, window_active;
    logic signed [SAMPLE_W-1:0] source_sample;
    logic        [SAMPLE_W-2:0] source_range;
    logic        [ADDR_W-1:0]   write_addr, display_start, display_center;
    logic        [2:0]          trig_mode;
    logic        [1:0]          slope_sel;
    logic signed [PCT_W-1:0]    level_pct, center_pct;
    logic        [PCT_W-1:0]    width_pct;
    logic        [POS_W-1:0]    pos_pct, pos_active;
    logic        [DELAY_W-1:0]  delay_steps, delay_active;
    int                         miscompares, n_compared, pulses, refusals;
    int                         base;

    trigger_qualifier #(.REC_LEN(REC)) trigger_qualifier_i (
        .mclk, .resetn, .sync_clear, .sample_valid, .source_sample,
        .source_range, .write_addr, .trig_mode, .auto_timed_out,
        .outside_trigger_connector, .ext_trig_pulse, .window_type,
        .window_leave, .slope_sel, .level_wr, .level_pct, .window_wr,
        .center_pct, .width_pct, .pos_wr, .pos_pct, .delay_wr,
        .delay_steps, .acq_run, .obs_time_change, .trig_pulse,
        .level_refused, .display_start, .display_center, .pos_active,
        .delay_active, .window_active);

    sample_source sample_source_i (.mclk, .sample_valid, .source_sample,
                                   .write_addr);

    always #5 mclk = ~mclk;

    // event counters, so pulse latency need not be pinned to one edge
    always @(posedge mclk)
    begin
        pulses   <= pulses + int'(trig_pulse === 1'b1);
        refusals <= refusals + int'(level_refused === 1'b1);
    end

    task automatic report_and_stop;
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic cfg(input int m, input int s, input int w,
                       input int l, input int e);
        @(negedge mclk);
        trig_mode                 = 3'(m);
        slope_sel                 = 2'(s);
        window_type               = 1'(w);
        window_leave              = 1'(l);
        outside_trigger_connector = 1'(e);
    endtask

    // one setting write; unused fields ride along harmlessly
    task automatic wr(input int k, input int v, input int w);
        @(negedge mclk);
        level_pct   <= 11'(v);
        center_pct  <= 11'(v);
        width_pct   <= 11'(w);
        pos_pct     <= 7'(v);
        delay_steps <= 21'(v);
        {level_wr, window_wr, pos_wr, delay_wr} <= 4'h8 >> k;
        @(negedge mclk);
        {level_wr, window_wr, pos_wr, delay_wr} <= 4'h0;
    endtask

    // forget history, send two samples, count the pulses that follow
    task automatic pair(input int a, input int b, input int exp,
                        input logic [ADDR_W-1:0] ad = 12'h000);
        int p0;
        p0 = pulses;
        @(negedge mclk);
        sync_clear <= 1'b1;
        @(negedge mclk);
        sync_clear <= 1'b0;
        sample_source_i.send(16'(a), ad);
        sample_source_i.send(16'(b), ad + 12'h001);
        tick(3);
        chk("pulses", exp, pulses - p0);
    endtask

    initial
    begin
        {mclk, resetn, sync_clear, auto_timed_out, ext_trig_pulse,
         outside_trigger_connector, window_type, window_leave, level_wr,
         window_wr, pos_wr, delay_wr, acq_run, obs_time_change} = '0;
        {trig_mode, slope_sel, level_pct, center_pct, width_pct} = '0;
        {pos_pct, delay_steps, pulses, refusals} = '0;
        {miscompares, n_compared} = '0;
        source_range = 15'h3e8; // one sample unit per tenth percent
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        // edge type, level crossings
        cfg(3, 0, 0, 0, 0);
        wr(LVL, 250, 0);
        pair(100, 400, 1);
        pair(400, 100, 0);
        pair(400, 400, 0);
        wr(LVL, 1001, 0);
        pair(200, 300, 1);
        wr(LVL, -250, 0);
        pair(-400, -100, 1);
        cfg(3, 1, 0, 0, 0);
        pair(-100, -400, 1);
        pair(-400, -100, 0);
        cfg(3, 2, 0, 0, 0);
        pair(-400, -100, 1);
        pair(-100, -400, 1);
        cfg(0, 2, 0, 0, 0);
        pair(-400, -100, 0);
        cfg(4, 2, 0, 0, 0);
        pair(-400, -100, 0);
        // auto-centre honours the level until its timeout runs out
        cfg(2, 2, 0, 0, 0);
        pair(-400, -100, 1);
        auto_timed_out = 1'b1;
        pair(-400, -100, 0);
        auto_timed_out = 1'b0;
        // level write in zero-cross mode is refused and dropped
        cfg(5, 2, 0, 0, 0);
        wr(LVL, 500, 0);
        tick(2);
        chk("refusals", 1, refusals);
        cfg(3, 2, 0, 0, 0);
        pair(-400, -100, 1);
        // outside source: samples and window ignored, pulse passes
        cfg(3, 0, 1, 0, 1);
        pair(-400, -100, 0);
        base = pulses;
        @(negedge mclk);
        ext_trig_pulse = 1'b1;
        @(negedge mclk);
        ext_trig_pulse = 1'b0;
        tick(3);
        chk("ext pulses", 1, pulses - base);
        chk("window_active", 0, window_active);
        // window band centre 0, width 40 percent
        cfg(3, 0, 1, 0, 0);
        wr(WIN, 0, 400);
        tick(2);
        chk("window_active", 1, window_active);
        pair(500, 100, 1);
        pair(100, -100, 0);
        cfg(3, 0, 1, 1, 0);
        pair(100, -500, 1);
        pair(500, 600, 0);
        wr(WIN, 900, 2000);
        pair(500, 1500, 1);
        cfg(2, 0, 1, 0, 0);
        tick(2);
        chk("window_active", 0, window_active);
        // position held while stopped, applied on start
        cfg(3, 0, 0, 0, 0);
        wr(LVL, 250, 0);
        wr(POS, 40, 0);
        tick(2);
        chk("pos_active", 0, pos_active);
        acq_run = 1'b1;
        tick(2);
        chk("pos_active", 40, pos_active);
        wr(POS, 101, 0);
        tick(2);
        chk("pos_active", 40, pos_active);
        pair(100, 400, 1, 12'h100);
        chk("display_start", 12'h0d9, display_start);
        wr(DLY, 2000001, 0);
        wr(DLY, 4, 0);
        tick(2);
        chk("delay_active", 4, delay_active);
        pair(100, 400, 1, 12'h200);
        chk("display_start", 12'h2a1, display_start);
        @(negedge mclk);
        obs_time_change = 1'b1;
        @(negedge mclk);
        obs_time_change = 1'b0;
        tick(2);
        chk("display_center", 12'h2c9, display_center);
        report_and_stop();
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
endmodule

bind trigger_qualifier trig_qual_chk #(.REC_LEN(REC_LEN)) trig_qual_chk_i (
    .mclk, .resetn, .sample_valid, .trig_mode, .outside_trigger_connector,
    .ext_trig_pulse, .level_wr, .acq_run, .trig_pulse, .level_refused,
    .pos_active, .delay_active, .window_active);

`default_nettype wire
